// ==== asm_pkg.sv ====
/*
 * constants shared by the alert status and mask logic: register offsets,
 * status and mask bit positions, reset values and shared-pin encodings.
 * assumes an 8-bit register port driven by the device's serial interface.
 */
package asm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets on the internal register port
    localparam logic [7:0] OFF_FAULT_STATUS_SECOND = 8'h42;
    localparam logic [7:0] OFF_ALERT_MASK_FIRST = 8'h74;
    localparam logic [7:0] OFF_ALERT_MASK_SECOND = 8'h75;

    ////////////////////////////////////////////////////////////////////////
    // reset values and unmapped read data
    localparam logic [7:0] RST_FAULT_STATUS_SECOND = 8'h00;
    localparam logic [7:0] RST_ALERT_MASK_FIRST = 8'h00;
    localparam logic [7:0] RST_ALERT_MASK_SECOND = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_DATA = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // bit positions of the second status and second mask registers
    localparam int BIT_REMOTE_DIODE_B_FAULT = 7;
    localparam int BIT_REMOTE_DIODE_A_FAULT = 6;
    localparam int BIT_FOURTH_FAN_OR_THERMAL = 5;
    localparam int BIT_THIRD_FAN = 4;
    localparam int BIT_SECOND_FAN = 3;
    localparam int BIT_FIRST_FAN = 2;
    localparam int BIT_OVERTEMP = 1;
    localparam int BIT_HIGH_RAIL_OR_ID = 0;

    // bit of the first mask register that masks the whole second register
    localparam int BIT_SECOND_REGISTER_SUMMARY = 7;

    ////////////////////////////////////////////////////////////////////////
    // shared pin 14 function codes
    localparam logic [1:0] PIN14_FOURTH_SPEED = 2'h0;
    localparam logic [1:0] PIN14_THERMAL = 2'h1;
    localparam logic [1:0] PIN14_ALERT = 2'h2;
    localparam logic [1:0] PIN14_GENERAL = 2'h3;

    // widths
    localparam int REG_WIDTH = 8;
    localparam int VID_WIDTH = 5;
    localparam int CHAN_WIDTH = 8;

endpackage

// ==== asm_window_if.sv ====
/*
 * interface joining the alert logic to its limit window comparator.
 * assumes both ends run in the mclk domain.
 */
`timescale 1ns/10ps
interface asm_window_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] value;
    logic [WIDTH-1:0] low_limit;
    logic [WIDTH-1:0] high_limit;
    logic over_high;
    logic under_low;

    // comparator end
    modport cmp (
        input value,
        input low_limit,
        input high_limit,
        output over_high,
        output under_low
    );

    // user end
    modport user (
        output value,
        output low_limit,
        output high_limit,
        input over_high,
        input under_low
    );
endinterface

// ==== asm_window_cmp.sv ====
/*
 * limit window comparator for one measurement channel.
 * assumes value and limits are unsigned and stable in the mclk domain.
 */
`timescale 1ns/10ps
module asm_window_cmp (
    asm_window_if.cmp win
);

    ////////////////////////////////////////////////////////////////////////
    // high limit is strictly greater, low limit is less or equal
    always_comb
    begin
        win.over_high = win.value > win.high_limit;
        win.under_low = win.value <= win.low_limit;
    end

endmodule

// ==== asm_alert_logic.sv ====
/*
 * second fault status register, the two alert mask registers and the
 * active-low alert output with its routing onto the two shared pins.
 * assumes condition levels come from mclk-domain monitor logic, that pin
 * configuration bits come from configuration registers held elsewhere and
 * reset to zero, and that the register port is driven by the serial slave.
 */
// Summary of operation
// - bits 7,6 flag remote diode open/short
// - bit 5 flags fourth fan/thermal/general pin
// - bits 4,3,2 flag slow fans 3,2,1
// - bit 1 set while overtemperature exceeded
// - bit 0 high rail violation or id change
// - sticky until read with condition gone
// - alert held until out-of-limit ends and read
// - overtemperature bit clears without a read
// - mask blocks alert only, status still sets
// - first mask bit 7 blocks second register
// - first mask bits 6..0 block first sources
// - second mask bits 7,6 block diode faults
// - second mask bit 5 blocks fourth source
// - second mask bits 4..2 block fans
// - second mask bits 1,0 block overtemp, rail
// - alert disabled after reset, routable
// - pin 10 carries alert or fan drive
// - summary bit set when any second bit set
// - over is greater, under is less-or-equal
`timescale 1ns/10ps
module asm_alert_logic #(
    parameter int VID_W = asm_pkg::VID_WIDTH,
    parameter int CHAN_W = asm_pkg::CHAN_WIDTH
)(
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // conditions from the monitor logic
    input wire logic remote_diode_b_fault,
    input wire logic remote_diode_a_fault,
    input wire logic fourth_fan_slow,
    input wire logic thermal_timer_over,
    input wire logic third_fan_flag,
    input wire logic second_fan_flag,
    input wire logic first_fan_flag,
    input wire logic overtemp_flag,
    input wire logic [CHAN_W-1:0] high_rail_value,
    input wire logic [CHAN_W-1:0] high_rail_low_limit,
    input wire logic [CHAN_W-1:0] high_rail_high_limit,
    input wire logic id_change_select,
    input wire logic [6:0] first_status_flags,
    // pins read by this block
    input wire logic shared_general_pin,
    input wire logic [VID_W-1:0] voltage_id_input,
    // pin configuration
    input wire logic pin10_alert_select,
    input wire logic [1:0] pin14_function,
    input wire logic second_fan_drive,
    // outputs
    output logic second_register_summary,
    output logic pin10_o,
    output logic pin10_oe_n,
    output logic pin14_o,
    output logic pin14_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (VID_W < 1 || VID_W > 8)
    begin : g_vid_check
        $error("voltage id width must be 1 to 8");
    end
    if (CHAN_W < 1)
    begin : g_chan_check
        $error("channel width must be positive");
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] fault_status_second;
        logic [7:0] alert_mask_first;
        logic [7:0] alert_mask_second;
        logic [7:0] rdata;
        logic gpio_meta;
        logic gpio_sync;
        logic [VID_W-1:0] vid_meta;
        logic [VID_W-1:0] vid_sync;
        logic [VID_W-1:0] vid_prev;
        logic vid_primed;
        logic summary;
        logic pin10_o;
        logic pin10_oe_n;
        logic pin14_o;
        logic pin14_oe_n;
    } asm_state_s;

    asm_state_s st;
    asm_state_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // 12 v window comparator

    asm_window_if #(.WIDTH(CHAN_W)) rail_win ();

    assign rail_win.value = high_rail_value;
    assign rail_win.low_limit = high_rail_low_limit;
    assign rail_win.high_limit = high_rail_high_limit;

    asm_window_cmp u_rail_cmp (
        .win(rail_win.cmp)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true when some source is set and its mask bit is clear
    function automatic logic unmasked_any(
        input logic [7:0] flags,
        input logic [7:0] mask
    );
        unmasked_any = |(flags & ~mask);
    endfunction

    // true when the register port addresses a given offset
    function automatic logic port_hit(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        port_hit = addr == offset;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // live conditions feeding the second status register

    logic [7:0] cond;
    logic id_changed;
    logic fourth_cond;
    logic alert_enabled;
    logic alert_req;
    logic status_read;

    // fourth source depends on the function of pin 14
    always_comb
    begin
        case (pin14_function)
            asm_pkg::PIN14_THERMAL: fourth_cond = thermal_timer_over;
            asm_pkg::PIN14_GENERAL: fourth_cond = st.gpio_sync;
            asm_pkg::PIN14_FOURTH_SPEED: fourth_cond = fourth_fan_slow;
            default: fourth_cond = 1'b0; // pin is the alert
        endcase
    end

    // id change compares the synchronised code with the previous one
    assign id_changed = st.vid_primed && (st.vid_sync != st.vid_prev);

    // condition vector in register bit order
    always_comb
    begin
        cond = 8'h00;
        cond[asm_pkg::BIT_REMOTE_DIODE_B_FAULT] = remote_diode_b_fault;
        cond[asm_pkg::BIT_REMOTE_DIODE_A_FAULT] = remote_diode_a_fault;
        cond[asm_pkg::BIT_FOURTH_FAN_OR_THERMAL] = fourth_cond;
        cond[asm_pkg::BIT_THIRD_FAN] = third_fan_flag;
        cond[asm_pkg::BIT_SECOND_FAN] = second_fan_flag;
        cond[asm_pkg::BIT_FIRST_FAN] = first_fan_flag;
        cond[asm_pkg::BIT_OVERTEMP] = overtemp_flag;
        if (id_change_select)
        begin
            cond[asm_pkg::BIT_HIGH_RAIL_OR_ID] = id_changed;
        end
        else
        begin
            cond[asm_pkg::BIT_HIGH_RAIL_OR_ID] =
                rail_win.over_high || rail_win.under_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert request from unmasked sources

    assign status_read = reg_rd &&
        port_hit(reg_addr, asm_pkg::OFF_FAULT_STATUS_SECOND);

    // alert enabled only when a pin is routed to it; config resets to 0
    assign alert_enabled = pin10_alert_select ||
        (pin14_function == asm_pkg::PIN14_ALERT);

    always_comb
    begin
        alert_req = 1'b0;
        // second register gated by its own mask and by first mask bit 7
        if (!st.alert_mask_first[asm_pkg::BIT_SECOND_REGISTER_SUMMARY]
            && unmasked_any(st.fault_status_second,
                st.alert_mask_second))
        begin
            alert_req = 1'b1;
        end
        // first register sources gated by first mask bits 6..0
        if (unmasked_any({1'b0, first_status_flags},
            {1'b1, st.alert_mask_first[6:0]}))
        begin
            alert_req = 1'b1;
        end
        alert_req = alert_req && alert_enabled;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_st = st;

        // pin synchronisers, first stage read only by second
        next_st.gpio_meta = shared_general_pin;
        next_st.gpio_sync = st.gpio_meta;
        next_st.vid_meta = voltage_id_input;
        next_st.vid_sync = st.vid_meta;
        next_st.vid_prev = st.vid_sync;
        next_st.vid_primed = 1'b1;

        // sticky status: read clears only bits whose condition is gone,
        // and a condition present in the read cycle keeps its bit set
        if (status_read)
        begin
            next_st.fault_status_second =
                (st.fault_status_second & cond) | cond;
        end
        else
        begin
            next_st.fault_status_second =
                st.fault_status_second | cond;
        end
        // overtemperature follows its condition with no read needed
        next_st.fault_status_second[asm_pkg::BIT_OVERTEMP] =
            cond[asm_pkg::BIT_OVERTEMP];

        // mask register writes; status writes are ignored
        if (reg_wr)
        begin
            if (port_hit(reg_addr, asm_pkg::OFF_ALERT_MASK_FIRST))
            begin
                next_st.alert_mask_first = reg_wdata;
            end
            else if (port_hit(reg_addr, asm_pkg::OFF_ALERT_MASK_SECOND))
            begin
                next_st.alert_mask_second = reg_wdata;
            end
        end

        // read data captured on the read strobe
        if (reg_rd)
        begin
            if (status_read)
            begin
                next_st.rdata = st.fault_status_second;
            end
            else if (port_hit(reg_addr, asm_pkg::OFF_ALERT_MASK_FIRST))
            begin
                next_st.rdata = st.alert_mask_first;
            end
            else if (port_hit(reg_addr, asm_pkg::OFF_ALERT_MASK_SECOND))
            begin
                next_st.rdata = st.alert_mask_second;
            end
            else
            begin
                next_st.rdata = asm_pkg::UNMAPPED_READ_DATA;
            end
        end

        // summary bit for the first status register
        next_st.summary = |next_st.fault_status_second;

        // pin 10: open-drain alert or push-pull second fan drive
        if (pin10_alert_select)
        begin
            next_st.pin10_o = 1'b0;
            next_st.pin10_oe_n = !alert_req;
        end
        else
        begin
            next_st.pin10_o = second_fan_drive;
            next_st.pin10_oe_n = 1'b0;
        end

        // pin 14: open-drain alert when so configured, else released here
        next_st.pin14_o = 1'b0;
        if (pin14_function == asm_pkg::PIN14_ALERT)
        begin
            next_st.pin14_oe_n = !alert_req;
        end
        else
        begin
            next_st.pin14_oe_n = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st.fault_status_second <= asm_pkg::RST_FAULT_STATUS_SECOND;
            st.alert_mask_first <= asm_pkg::RST_ALERT_MASK_FIRST;
            st.alert_mask_second <= asm_pkg::RST_ALERT_MASK_SECOND;
            st.rdata <= asm_pkg::RST_READ_DATA;
            st.gpio_meta <= 1'b0;
            st.gpio_sync <= 1'b0;
            st.vid_meta <= '0;
            st.vid_sync <= '0;
            st.vid_prev <= '0;
            st.vid_primed <= 1'b0;
            st.summary <= 1'b0;
            st.pin10_o <= 1'b0;
            st.pin10_oe_n <= 1'b1; // alert function off after reset
            st.pin14_o <= 1'b0;
            st.pin14_oe_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs from flip-flops

    assign reg_rdata = st.rdata;
    assign second_register_summary = st.summary;
    assign pin10_o = st.pin10_o;
    assign pin10_oe_n = st.pin10_oe_n;
    assign pin14_o = st.pin14_o;
    assign pin14_oe_n = st.pin14_oe_n;

endmodule

// ==== asm_alert_props.sv ====
/*
 * checker for the alert status and mask logic ports.
 * assumes a bind onto asm_alert_logic; one mclk domain.
 */
`timescale 1ns/10ps
module asm_alert_props (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic remote_diode_b_fault,
    input wire logic overtemp_flag,
    input wire logic pin10_alert_select,
    input wire logic [1:0] pin14_function,
    input wire logic second_fan_drive,
    input wire logic second_register_summary,
    input wire logic pin10_o,
    input wire logic pin10_oe_n,
    input wire logic pin14_o,
    input wire logic pin14_oe_n
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // pin routing and drive levels
    fan_drive_pass_a: assert property (
        !$past(sys_rst) && !$past(pin10_alert_select) |->
        !pin10_oe_n && pin10_o == $past(second_fan_drive))
        else $error("pin10 not carrying fan drive");
    alert_only_low_a: assert property (
        !$past(sys_rst) && $past(pin10_alert_select) |-> !pin10_o)
        else $error("pin10 alert drives high");
    pin14_level_a: assert property (!pin14_o)
        else $error("pin14 drives high");
    pin14_release_a: assert property (
        !$past(sys_rst) && $past(pin14_function) != asm_pkg::PIN14_ALERT
        |-> pin14_oe_n)
        else $error("pin14 driven outside alert function");
    pins_agree_a: assert property (
        $past(pin10_alert_select) && pin10_alert_select &&
        $past(pin14_function) == asm_pkg::PIN14_ALERT && !$past(sys_rst)
        |-> pin14_oe_n == pin10_oe_n)
        else $error("alert pins disagree");
    // status summary and read data behaviour
    diode_summary_a: assert property (
        remote_diode_b_fault |-> ##[1:3] second_register_summary)
        else $error("diode fault not summarised");
    summary_sticky_a: assert property (
        second_register_summary && !reg_rd && !$past(reg_rd) &&
        !$past(overtemp_flag)
        |=> second_register_summary)
        else $error("summary dropped without a read");
    read_stands_a: assert property (
        !$past(reg_rd) && !$past(reg_rd, 2) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule

// ==== asm_host_model.sv ====
/*
 * host on the register port: one-cycle write and read strobes.
 * assumes read data lands within two edges of the read strobe.
 */
`timescale 1ns/10ps
module asm_host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle port at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // write strobe; data is scrambled once released
    task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~v;
    endtask

    // status polls by the handler go through here
    task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge mclk);
        v = reg_rdata;
    endtask
endmodule

// ==== testbench.sv ====
/*
 * self-checking bench for the alert status and mask logic.
 * assumes asm_pkg, asm_host_model and asm_alert_props compiled first.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    $display("Error %s expected %h seen %h", n, e, g); fails++; end end
module testbench;
    localparam logic [7:0] a_st = asm_pkg::OFF_FAULT_STATUS_SECOND;
    localparam logic [7:0] a_m1 = asm_pkg::OFF_ALERT_MASK_FIRST;
    localparam logic [7:0] a_m2 = asm_pkg::OFF_ALERT_MASK_SECOND;
    logic mclk, sys_rst, reg_wr, reg_rd, thermal_signal_over, gpin, alert_sel;
    logic fan_drive, summary, p10_o, p10_oe_n, p14_o, p14_oe_n, e, id_sel;
    logic [4:0] vid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, src, rail, d;
    logic [6:0] ff;
    logic [1:0] func;
    logic [8:0] rail_tab [4] = '{9'h0f0, 9'h1f1, 9'h110, 9'h011};
    int fails = 0;
    int num_checks = 0;

    asm_host_model host (.mclk(mclk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    asm_alert_logic uut (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .remote_diode_b_fault(src[7]),
        .remote_diode_a_fault(src[6]), .fourth_fan_slow(src[5]),
        .thermal_timer_over(thermal_signal_over), .third_fan_flag(src[4]),
        .second_fan_flag(src[3]), .first_fan_flag(src[2]),
        .overtemp_flag(src[1]), .high_rail_value(rail),
        .high_rail_low_limit(8'h10), .high_rail_high_limit(8'hf0),
        .id_change_select(id_sel), .first_status_flags(ff),
        .shared_general_pin(gpin), .voltage_id_input(vid),
        .pin10_alert_select(alert_sel), .pin14_function(func),
        .second_fan_drive(fan_drive), .second_register_summary(summary),
        .pin10_o(p10_o), .pin10_oe_n(p10_oe_n), .pin14_o(p14_o),
        .pin14_oe_n(p14_oe_n));

    ////////////////////////////////////////////////////////////////////////
    // clock, helpers and closing
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic alert_exp(input logic [7:0] st, m1, m2,
        input logic [6:0] f);
        return (|(st & ~m2) & ~m1[7]) | (|(f & ~m1[6:0]));
    endfunction
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, e8, input string n);
        host.read_reg(a, d);
        `CHK(n, e8, d)
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // random masks and sources, then hold, read and release
    task automatic rand_case();
        logic [7:0] c, m1, m2;
        logic [6:0] f;
        c = 8'($urandom());
        m1 = 8'($urandom());
        m2 = 8'($urandom());
        f = 7'($urandom());
        host.write_reg(a_m1, m1);
        host.write_reg(a_m2, m2);
        rd_chk(a_m1, m1, "mask1");
        rd_chk(a_m2, m2, "mask2");
        src = c;
        rail = c[0] ? 8'hf1 : 8'h80;
        ff = f;
        wait_n(4);
        `CHK("alert", ~alert_exp(c, m1, m2, f), p10_oe_n)
        `CHK("summary", |c, summary)
        rd_chk(a_st, c, "status live");
        src = 8'h00;
        rail = 8'h80;
        ff = 7'h00;
        wait_n(3);
        e = ~alert_exp(c & 8'hfd, m1, m2, 7'h00);
        `CHK("alert held", e, p10_oe_n)
        rd_chk(a_st, c & 8'hfd, "status sticky");
        wait_n(3);
        `CHK("released", 1'b1, p10_oe_n)
        `CHK("summary off", 1'b0, summary)
        rd_chk(a_st, 8'h00, "status clear");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        src = 8'h00;
        rail = 8'h80;
        ff = 7'h00;
        thermal_signal_over = 1'b0;
        gpin = 1'b0;
        alert_sel = 1'b0;
        func = 2'h0;
        fan_drive = 1'b1;
        id_sel = 1'b0;
        vid = 5'h00;
        void'($urandom(85));
        repeat (16) @(posedge mclk);
        @(negedge mclk) sys_rst = 1'b0;
        rd_chk(a_st, 8'h00, "status2 reset");
        rd_chk(a_m1, 8'h00, "mask1 reset");
        rd_chk(a_m2, 8'h00, "mask2 reset");
        rd_chk(8'h10, 8'h00, "unmapped");
        host.write_reg(a_st, 8'hff);
        rd_chk(a_st, 8'h00, "status2 write");
        repeat (2)
        begin
            fan_drive = ~fan_drive;
            wait_n(2);
            `CHK("pin10 out", fan_drive, p10_o)
            `CHK("pin14 oe_n", 1'b1, p14_oe_n)
        end
        $display("test defaults done");
        for (int i = 0; i < 4; i++)
        begin
            rail = rail_tab[i][7:0];
            wait_n(3);
            rail = 8'h80;
            wait_n(3);
            rd_chk(a_st, {7'h00, rail_tab[i][8]}, "rail");
        end
        id_sel = 1'b1;
        wait_n(6);
        rd_chk(a_st, 8'h00, "id steady");
        vid = 5'($urandom()) | 5'h01;
        wait_n(6);
        rd_chk(a_st, 8'h01, "id change");
        rd_chk(a_st, 8'h00, "id cleared");
        id_sel = 1'b0;
        wait_n(2);
        $display("test rail limits done");
        alert_sel = 1'b1;
        for (int f = 0; f < 4; f++)
        begin
            if (f == 2)
                continue;
            func = 2'(f);
            src[5] = (f != 0);
            thermal_signal_over = (f != 1);
            gpin = (f != 3);
            wait_n(6);
            rd_chk(a_st, 8'h00, "bit5 other");
            src[5] = 1'b1;
            thermal_signal_over = 1'b1;
            gpin = 1'b1;
            wait_n(6);
            `CHK("bit5 alert", 1'b0, p10_oe_n)
            host.write_reg(a_m2, 8'h20);
            wait_n(3);
            `CHK("bit5 masked", 1'b1, p10_oe_n)
            src[5] = 1'b0;
            thermal_signal_over = 1'b0;
            gpin = 1'b0;
            wait_n(6);
            rd_chk(a_st, 8'h20, "bit5 sticky");
            host.write_reg(a_m2, 8'h00);
        end
        $display("test fourth source done");
        func = asm_pkg::PIN14_ALERT;
        src = 8'h04;
        wait_n(4);
        `CHK("pin14 alert", 1'b0, p14_oe_n)
        rd_chk(a_st, 8'h04, "handler read");
        host.write_reg(a_m2, 8'h04);
        wait_n(3);
        `CHK("fan masked", 1'b1, p14_oe_n)
        src = 8'h00;
        wait_n(3);
        rd_chk(a_st, 8'h04, "poll sticky");
        rd_chk(a_st, 8'h00, "poll clear");
        host.write_reg(a_m2, 8'h00);
        wait_n(3);
        `CHK("unmasked idle", 1'b1, p14_oe_n)
        $display("test handler done");
        func = 2'h0;
        repeat (40) rand_case();
        $display("test random done");
        close_out();
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        close_out();
    end
endmodule

bind asm_alert_logic asm_alert_props u_props (
    .mclk(mclk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .remote_diode_b_fault(remote_diode_b_fault),
    .overtemp_flag(overtemp_flag),
    .pin10_alert_select(pin10_alert_select),
    .pin14_function(pin14_function), .second_fan_drive(second_fan_drive),
    .second_register_summary(second_register_summary),
    .pin10_o(pin10_o), .pin10_oe_n(pin10_oe_n), .pin14_o(pin14_o),
    .pin14_oe_n(pin14_oe_n));
